// File: pkg/gpeb_pkg.sv
// Register map, field widths and reset values for the GPIO edge enable block
package gpeb_pkg;

	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Pin counts per bank
	localparam int BANK0_W = 32;
	localparam int BANK1_W = 18;

	// Synchroniser depth on pin inputs
	localparam int SYNC_STAGES = 3;

	// Pin level, readable enables and edge status
	localparam logic [11:0] OFS_LEVEL_B0 = 12'h000;
	localparam logic [11:0] OFS_LEVEL_B1 = 12'h004;
	localparam logic [11:0] OFS_RISE_EN_B0 = 12'h030;
	localparam logic [11:0] OFS_RISE_EN_B1 = 12'h034;
	localparam logic [11:0] OFS_FALL_EN_B0 = 12'h03C;
	localparam logic [11:0] OFS_FALL_EN_B1 = 12'h040;
	localparam logic [11:0] OFS_STATUS_B0 = 12'h048;
	localparam logic [11:0] OFS_STATUS_B1 = 12'h04C;

	// Bitwise set and clear of the edge enables
	localparam logic [11:0] OFS_RISE_SET_B0 = 12'h06C;
	localparam logic [11:0] OFS_RISE_SET_B1 = 12'h070;
	localparam logic [11:0] OFS_RISE_CLR_B0 = 12'h078;
	localparam logic [11:0] OFS_RISE_CLR_B1 = 12'h07C;
	localparam logic [11:0] OFS_FALL_SET_B0 = 12'h084;
	localparam logic [11:0] OFS_FALL_SET_B1 = 12'h088;
	localparam logic [11:0] OFS_FALL_CLR_B0 = 12'h090;
	localparam logic [11:0] OFS_FALL_CLR_B1 = 12'h094;

	// Edge status mask
	localparam logic [11:0] OFS_MASK_B0 = 12'h09C;
	localparam logic [11:0] OFS_MASK_B1 = 12'h0A0;

	// Reset values
	localparam logic [31:0] RST_B0 = 32'h0000_0000;
	localparam logic [17:0] RST_B1 = 18'h0_0000;

endpackage

// File: hdl/gpeb_pin_sync.sv
// Pin input synchroniser with agreed-level tracking and edge pulses
`timescale 1ns/1ps

module gpeb_pin_sync #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Raw pins from outside the clock domain
	input wire logic [WIDTH-1:0] pin_in,
	// Settled level and one-cycle edge pulses
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);

	// Three flops; stage one is read only by stage two
	logic [WIDTH-1:0] s1_r, s2_r, s3_r;
	logic [WIDTH-1:0] s1_nxt, s2_nxt, s3_nxt;
	// Accepted level, moves only when stages two and three agree
	logic [WIDTH-1:0] level_r, level_nxt;

	// Next-state for the chain and the accepted level
	always_comb begin
		s1_nxt = pin_in;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		// A single-cycle glitch never reaches both stages, so it is dropped
		level_nxt = (s2_r & s3_r) | (level_r & (s2_r | s3_r));
	end

	// Registers only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			level_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			level_r <= level_nxt;
		end
	end

	// Edges are the change of the accepted level, one cycle each
	assign level = level_r;
	assign rise = level_nxt & ~level_r;
	assign fall = ~level_nxt & level_r;

endmodule // gpeb_pin_sync

// File: hdl/gpeb_top.sv
// APB register block for GPIO edge enables, edge status and its mask
// What this block does
// - Rise set write sets enables where one
// - Rise clear write clears enables where one
// - Fall set write sets enables where one
// - Fall clear write clears enables where one
// - Per-pin mask bit: zero masks, one passes
// - Mask bits reset to zero
// - Bank one implements bits seventeen to zero
// - Enabled rising pin edge sets status bit
// - Enabled falling pin edge sets status bit
// - Status sticky, cleared by writing one
`timescale 1ns/1ps

module gpeb_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pin inputs, both banks
	input wire logic [31:0] gpio_in_b0,
	input wire logic [17:0] gpio_in_b1,
	// Enable and status vectors toward the rest of the port
	output logic [31:0] rise_en_b0,
	output logic [17:0] rise_en_b1,
	output logic [31:0] fall_en_b0,
	output logic [17:0] fall_en_b1,
	output logic [31:0] edge_status_b0,
	output logic [17:0] edge_status_b1,
	// Combined edge event request
	output logic irq
);

	// Bitwise set then clear; a word with both bits sees the clear last
	function automatic logic [31:0] set_clr(input logic [31:0] cur,
		input logic [31:0] set_bits, input logic [31:0] clr_bits);
		set_clr = (cur | set_bits) & ~clr_bits;
	endfunction

	// Address compare, used for every register
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction

	// Rising and falling enables per bank
	logic [31:0] rise_b0_r, rise_b0_nxt;
	logic [17:0] rise_b1_r, rise_b1_nxt;
	logic [31:0] fall_b0_r, fall_b0_nxt;
	logic [17:0] fall_b1_r, fall_b1_nxt;
	// Interrupt mask per bank, gates status into the request
	logic [31:0] mask_b0_r, mask_b0_nxt;
	logic [17:0] mask_b1_r, mask_b1_nxt;
	// Sticky edge status per bank
	logic [31:0] stat_b0_r, stat_b0_nxt;
	logic [17:0] stat_b1_r, stat_b1_nxt;
	// Registered read data and error
	logic [31:0] rdata_r, rdata_nxt;
	logic err_r, err_nxt;
	// Registered interrupt level
	logic irq_r, irq_nxt;

	// Synchronised pins and their edges
	logic [31:0] lvl_b0, rise_p_b0, fall_p_b0;
	logic [17:0] lvl_b1, rise_p_b1, fall_p_b1;

	// Bus phase decodes
	logic setup_ph;
	logic wr_acc;
	logic known;
	// Write data seen by bank one, upper bits dropped
	logic [31:0] wd_b1;
	// Per-register write strobes, full width
	logic [31:0] w_rs0, w_rs1, w_rc0, w_rc1;
	logic [31:0] w_fs0, w_fs1, w_fc0, w_fc1;
	logic [31:0] w_st0, w_st1;
	// Edge events per bank
	logic [31:0] ev_b0;
	logic [17:0] ev_b1;
	// Widened bank one values for the shared function
	logic [31:0] upd_r1, upd_f1;

	// Bank zero pin synchroniser
	gpeb_pin_sync #(
		.WIDTH(gpeb_pkg::BANK0_W)
	) u_sync_b0 (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(gpio_in_b0),
		.level(lvl_b0),
		.rise(rise_p_b0),
		.fall(fall_p_b0)
	);

	// Bank one pin synchroniser
	gpeb_pin_sync #(
		.WIDTH(gpeb_pkg::BANK1_W)
	) u_sync_b1 (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(gpio_in_b1),
		.level(lvl_b1),
		.rise(rise_p_b1),
		.fall(fall_p_b1)
	);

	// Address decode; zero-wait slave so the access phase ends at once
	always_comb begin
		setup_ph = psel & ~penable;
		wr_acc = psel & penable & pwrite;
		known = hit(paddr, gpeb_pkg::OFS_LEVEL_B0) | hit(paddr, gpeb_pkg::OFS_LEVEL_B1)
			| hit(paddr, gpeb_pkg::OFS_RISE_EN_B0) | hit(paddr, gpeb_pkg::OFS_RISE_EN_B1)
			| hit(paddr, gpeb_pkg::OFS_FALL_EN_B0) | hit(paddr, gpeb_pkg::OFS_FALL_EN_B1)
			| hit(paddr, gpeb_pkg::OFS_STATUS_B0) | hit(paddr, gpeb_pkg::OFS_STATUS_B1)
			| hit(paddr, gpeb_pkg::OFS_RISE_SET_B0) | hit(paddr, gpeb_pkg::OFS_RISE_SET_B1)
			| hit(paddr, gpeb_pkg::OFS_RISE_CLR_B0) | hit(paddr, gpeb_pkg::OFS_RISE_CLR_B1)
			| hit(paddr, gpeb_pkg::OFS_FALL_SET_B0) | hit(paddr, gpeb_pkg::OFS_FALL_SET_B1)
			| hit(paddr, gpeb_pkg::OFS_FALL_CLR_B0) | hit(paddr, gpeb_pkg::OFS_FALL_CLR_B1)
			| hit(paddr, gpeb_pkg::OFS_MASK_B0) | hit(paddr, gpeb_pkg::OFS_MASK_B1);
		// upper bits ignored, so stray ones are harmless
		wd_b1 = {14'h0000, pwdata[17:0]};
	end

	// Write strobes: data where the access is a write to that address
	always_comb begin
		w_rs0 = (wr_acc && hit(paddr, gpeb_pkg::OFS_RISE_SET_B0)) ? pwdata : 32'h0000_0000;
		w_rs1 = (wr_acc && hit(paddr, gpeb_pkg::OFS_RISE_SET_B1)) ? wd_b1 : 32'h0000_0000;
		w_rc0 = (wr_acc && hit(paddr, gpeb_pkg::OFS_RISE_CLR_B0)) ? pwdata : 32'h0000_0000;
		w_rc1 = (wr_acc && hit(paddr, gpeb_pkg::OFS_RISE_CLR_B1)) ? wd_b1 : 32'h0000_0000;
		w_fs0 = (wr_acc && hit(paddr, gpeb_pkg::OFS_FALL_SET_B0)) ? pwdata : 32'h0000_0000;
		w_fs1 = (wr_acc && hit(paddr, gpeb_pkg::OFS_FALL_SET_B1)) ? wd_b1 : 32'h0000_0000;
		w_fc0 = (wr_acc && hit(paddr, gpeb_pkg::OFS_FALL_CLR_B0)) ? pwdata : 32'h0000_0000;
		w_fc1 = (wr_acc && hit(paddr, gpeb_pkg::OFS_FALL_CLR_B1)) ? wd_b1 : 32'h0000_0000;
		w_st0 = (wr_acc && hit(paddr, gpeb_pkg::OFS_STATUS_B0)) ? pwdata : 32'h0000_0000;
		w_st1 = (wr_acc && hit(paddr, gpeb_pkg::OFS_STATUS_B1)) ? wd_b1 : 32'h0000_0000;
	end

	// Enable next values
	always_comb begin
		rise_b0_nxt = set_clr(rise_b0_r, w_rs0, w_rc0);
		upd_r1 = set_clr({14'h0000, rise_b1_r}, w_rs1, w_rc1);
		rise_b1_nxt = upd_r1[17:0];
		fall_b0_nxt = set_clr(fall_b0_r, w_fs0, w_fc0);
		upd_f1 = set_clr({14'h0000, fall_b1_r}, w_fs1, w_fc1);
		fall_b1_nxt = upd_f1[17:0];
	end

	// Enable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_b0_r <= gpeb_pkg::RST_B0;
			rise_b1_r <= gpeb_pkg::RST_B1;
			fall_b0_r <= gpeb_pkg::RST_B0;
			fall_b1_r <= gpeb_pkg::RST_B1;
		end else begin
			rise_b0_r <= rise_b0_nxt;
			rise_b1_r <= rise_b1_nxt;
			fall_b0_r <= fall_b0_nxt;
			fall_b1_r <= fall_b1_nxt;
		end
	end

	// Mask next values, plain read-write
	always_comb begin
		mask_b0_nxt = mask_b0_r;
		mask_b1_nxt = mask_b1_r;
		if (wr_acc && hit(paddr, gpeb_pkg::OFS_MASK_B0)) begin
			mask_b0_nxt = pwdata;
		end
		if (wr_acc && hit(paddr, gpeb_pkg::OFS_MASK_B1)) begin
			mask_b1_nxt = wd_b1[17:0];
		end
	end

	// Mask registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_b0_r <= gpeb_pkg::RST_B0;
			mask_b1_r <= gpeb_pkg::RST_B1;
		end else begin
			mask_b0_r <= mask_b0_nxt;
			mask_b1_r <= mask_b1_nxt;
		end
	end

	// Sticky status next values
	always_comb begin
		ev_b0 = (rise_p_b0 & rise_b0_r) | (fall_p_b0 & fall_b0_r);
		ev_b1 = (rise_p_b1 & rise_b1_r) | (fall_p_b1 & fall_b1_r);
		// write one clears, new edge wins
		stat_b0_nxt = (stat_b0_r & ~w_st0) | ev_b0;
		stat_b1_nxt = (stat_b1_r & ~w_st1[17:0]) | ev_b1;
	end

	// Status registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_b0_r <= gpeb_pkg::RST_B0;
			stat_b1_r <= gpeb_pkg::RST_B1;
		end else begin
			stat_b0_r <= stat_b0_nxt;
			stat_b1_r <= stat_b1_nxt;
		end
	end

	// Interrupt level from next status, so it follows status by no extra cycle
	always_comb begin
		irq_nxt = |(stat_b0_nxt & mask_b0_nxt) | |(stat_b1_nxt & mask_b1_nxt);
	end

	// Interrupt register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// Read mux, captured in the setup cycle; write-only registers read zero
	always_comb begin
		rdata_nxt = rdata_r;
		err_nxt = err_r;
		if (setup_ph) begin
			err_nxt = ~known;
			rdata_nxt = 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					gpeb_pkg::OFS_LEVEL_B0: begin
						rdata_nxt = lvl_b0;
					end
					gpeb_pkg::OFS_LEVEL_B1: begin
						rdata_nxt = {14'h0000, lvl_b1};
					end
					gpeb_pkg::OFS_RISE_EN_B0: begin
						rdata_nxt = rise_b0_r;
					end
					gpeb_pkg::OFS_RISE_EN_B1: begin
						rdata_nxt = {14'h0000, rise_b1_r};
					end
					gpeb_pkg::OFS_FALL_EN_B0: begin
						rdata_nxt = fall_b0_r;
					end
					gpeb_pkg::OFS_FALL_EN_B1: begin
						rdata_nxt = {14'h0000, fall_b1_r};
					end
					gpeb_pkg::OFS_STATUS_B0: begin
						rdata_nxt = stat_b0_r;
					end
					gpeb_pkg::OFS_STATUS_B1: begin
						rdata_nxt = {14'h0000, stat_b1_r};
					end
					gpeb_pkg::OFS_MASK_B0: begin
						rdata_nxt = mask_b0_r;
					end
					gpeb_pkg::OFS_MASK_B1: begin
						rdata_nxt = {14'h0000, mask_b1_r};
					end
					default: begin
						// Write-only and unmapped read as zero
						rdata_nxt = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// Read data and error registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
		end
	end

	// Status seen by a read is the value one cycle before the access edge
	assign prdata = rdata_r;
	assign pready = 1'b1;
	assign pslverr = psel & penable & err_r;

	// Vectors toward the port
	assign rise_en_b0 = rise_b0_r;
	assign rise_en_b1 = rise_b1_r;
	assign fall_en_b0 = fall_b0_r;
	assign fall_en_b1 = fall_b1_r;
	assign edge_status_b0 = stat_b0_r;
	assign edge_status_b1 = stat_b1_r;
	assign irq = irq_r;

endmodule // gpeb_top

// File: test/gpeb_props.sv
// Port-level assertions for the GPIO edge enable block
`timescale 1ns/1ps
module gpeb_props (
	// Clock, reset and bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Pins
	input wire logic [31:0] gpio_in_b0,
	input wire logic [17:0] gpio_in_b1,
	// Enables, status and request
	input wire logic [31:0] rise_en_b0,
	input wire logic [17:0] rise_en_b1,
	input wire logic [31:0] fall_en_b0,
	input wire logic [17:0] fall_en_b1,
	input wire logic [31:0] edge_status_b0,
	input wire logic [17:0] edge_status_b1,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Write takes effect at the access edge only
	logic wr;
	assign wr = psel & penable & pwrite;
	property p_rs0;
		wr && paddr == gpeb_pkg::OFS_RISE_SET_B0 |=> rise_en_b0 == ($past(rise_en_b0) | $past(pwdata));
	endproperty
	a_rs0: assert property (p_rs0) else $error("rise set bank0 wrong");
	property p_rc0;
		wr && paddr == gpeb_pkg::OFS_RISE_CLR_B0 |=> rise_en_b0 == ($past(rise_en_b0) & ~$past(pwdata));
	endproperty
	a_rc0: assert property (p_rc0) else $error("rise clear bank0 wrong");
	property p_fs0;
		wr && paddr == gpeb_pkg::OFS_FALL_SET_B0 |=> fall_en_b0 == ($past(fall_en_b0) | $past(pwdata));
	endproperty
	a_fs0: assert property (p_fs0) else $error("fall set bank0 wrong");
	property p_fc1;
		wr && paddr == gpeb_pkg::OFS_FALL_CLR_B1 |=> fall_en_b1 == ($past(fall_en_b1) & ~$past(pwdata[17:0]));
	endproperty
	a_fc1: assert property (p_fc1) else $error("fall clear bank1 wrong");
	property p_rs1;
		wr && paddr == gpeb_pkg::OFS_RISE_SET_B1 |=> rise_en_b1 == ($past(rise_en_b1) | $past(pwdata[17:0]));
	endproperty
	a_rs1: assert property (p_rs1) else $error("rise set bank1 wrong");
	// Three synchroniser stages between pin and status
	property p_rise;
		$rose(gpio_in_b0[0]) ##1 (gpio_in_b0[0] && rise_en_b0[0])[*3] |=> edge_status_b0[0];
	endproperty
	a_rise: assert property (p_rise) else $error("enabled rise not recorded");
	property p_fall;
		$fell(gpio_in_b1[17]) ##1 (!gpio_in_b1[17] && fall_en_b1[17])[*3] |=> edge_status_b1[17];
	endproperty
	a_fall: assert property (p_fall) else $error("enabled fall not recorded");
	property p_stick;
		!(wr && paddr == gpeb_pkg::OFS_STATUS_B0) |=> (edge_status_b0 & $past(edge_status_b0)) == $past(edge_status_b0);
	endproperty
	a_stick: assert property (p_stick) else $error("status bit lost");
	property p_irq;
		irq |-> (edge_status_b0 != 32'h0 || edge_status_b1 != 18'h0);
	endproperty
	a_irq: assert property (p_irq) else $error("request without status");
endmodule // gpeb_props

// File: test/gpeb_pin_model.sv
// Outside-world pin driver for the GPIO edge enable block
`timescale 1ns/1ps
module gpeb_pin_model (
	// Clock
	input wire logic pclk,
	// Levels requested by the bench
	input wire logic [31:0] want_b0,
	input wire logic [17:0] want_b1,
	// Pins toward the block
	output logic [31:0] pin_b0,
	output logic [17:0] pin_b1
);
	// Pins start low so no stray edge follows reset
	initial begin
		pin_b0 = 32'h0;
		pin_b1 = 18'h0;
	end
	// Clean, held levels; no glitches are made
	always @(posedge pclk) begin
		pin_b0 <= want_b0;
		pin_b1 <= want_b1;
	end
endmodule // gpeb_pin_model

// File: test/gpeb_test.sv
// Register-level test of the GPIO edge enable block
`timescale 1ns/1ps
module gpeb_test;
	// Bus, pins and outputs
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, rise_en_b0, fall_en_b0, edge_status_b0, want_b0, gpio_in_b0;
	logic [17:0] rise_en_b1, fall_en_b1, edge_status_b1, want_b1, gpio_in_b1;
	int n_mismatch = 0;
	int total_checks = 0;
	gpeb_top gpeb_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .gpio_in_b0, .gpio_in_b1, .rise_en_b0, .rise_en_b1, .fall_en_b0, .fall_en_b1,
		.edge_status_b0, .edge_status_b1, .irq);
	gpeb_pin_model gpeb_pin_model_inst (.pclk, .want_b0, .want_b1, .pin_b0(gpio_in_b0), .pin_b1(gpio_in_b1));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One transfer; an idle edge after it avoids double drives
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			n_mismatch++;
			$display("[ERR] %0t pready got %h exp %h", $time, pready, 1'b1);
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// Set twice, clear some, clear all; reserved bank one bits go as zero
	task automatic sc(input logic [11:0] s, input logic [11:0] c, input logic [11:0] r, input logic [31:0] m);
		apb(1'b1, s, 32'h8000_0001 & m);
		apb(1'b1, s, 32'h0F0F_0F0F & m);
		rdc(r, 32'h8F0F_0F0F & m);
		apb(1'b1, c, 32'h8F00_000E & m);
		rdc(r, 32'h000F_0F01 & m);
		apb(1'b1, c, m);
		rdc(r, 32'h0);
	endtask
	// Bounded wait on a status bit
	task automatic wt(input logic b1);
		int i;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if ((b1 ? edge_status_b1[17] : edge_status_b0[0]) === 1'b1) break;
		end
		if (i == 16) begin
			n_mismatch++;
			$display("[ERR] %0t status got %h exp %h", $time, (b1 ? edge_status_b1[17] : edge_status_b0[0]), 1'b1);
			conclude();
		end
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		want_b0 = 32'h0;
		want_b1 = 18'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(gpeb_pkg::OFS_MASK_B0, 32'h0);
		rdc(gpeb_pkg::OFS_MASK_B1, 32'h0);
		sc(gpeb_pkg::OFS_RISE_SET_B0, gpeb_pkg::OFS_RISE_CLR_B0, gpeb_pkg::OFS_RISE_EN_B0, 32'hFFFF_FFFF);
		sc(gpeb_pkg::OFS_RISE_SET_B1, gpeb_pkg::OFS_RISE_CLR_B1, gpeb_pkg::OFS_RISE_EN_B1, 32'h0003_FFFF);
		sc(gpeb_pkg::OFS_FALL_SET_B0, gpeb_pkg::OFS_FALL_CLR_B0, gpeb_pkg::OFS_FALL_EN_B0, 32'hFFFF_FFFF);
		sc(gpeb_pkg::OFS_FALL_SET_B1, gpeb_pkg::OFS_FALL_CLR_B1, gpeb_pkg::OFS_FALL_EN_B1, 32'h0003_FFFF);
		apb(1'b1, gpeb_pkg::OFS_MASK_B0, 32'h1234_5678);
		rdc(gpeb_pkg::OFS_MASK_B0, 32'h1234_5678);
		apb(1'b1, gpeb_pkg::OFS_MASK_B1, 32'h0001_5678);
		rdc(gpeb_pkg::OFS_MASK_B1, 32'h0001_5678);
		// Unmapped place is refused
		rdc(12'h0F0, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, gpeb_pkg::OFS_MASK_B0, 32'h0);
		// Pin 0 rise enabled, pin 1 not; bank one pin 17 fall only
		apb(1'b1, gpeb_pkg::OFS_RISE_SET_B0, 32'h0000_0001);
		apb(1'b1, gpeb_pkg::OFS_FALL_SET_B1, 32'h0002_0000);
		want_b0 <= 32'h0000_0003;
		want_b1 <= 18'h2_0000;
		wt(1'b0);
		rdc(gpeb_pkg::OFS_STATUS_B0, 32'h1);
		chk({14'h0, edge_status_b1}, 32'h0);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, gpeb_pkg::OFS_MASK_B0, 32'h1);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, gpeb_pkg::OFS_STATUS_B0, 32'h1);
		chk(edge_status_b0, 32'h0);
		chk({31'h0, irq}, 32'h0);
		want_b1 <= 18'h0;
		wt(1'b1);
		rdc(gpeb_pkg::OFS_STATUS_B1, 32'h0002_0000);
		chk({31'h0, irq}, 32'h0);
		// Settled pin levels read back
		rdc(gpeb_pkg::OFS_LEVEL_B0, 32'h0000_0003);
		// Bank one unmask raises the request, its clear drops it
		apb(1'b1, gpeb_pkg::OFS_MASK_B1, 32'h0002_0000);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, gpeb_pkg::OFS_STATUS_B1, 32'h0002_0000);
		chk({14'h0, edge_status_b1}, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// Mid-run reset must mask every pin again
		apb(1'b1, gpeb_pkg::OFS_MASK_B0, 32'hFFFF_FFFF);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(gpeb_pkg::OFS_MASK_B0, 32'h0);
		rdc(gpeb_pkg::OFS_MASK_B1, 32'h0);
		chk({31'h0, irq}, 32'h0);
		conclude();
	end
endmodule // gpeb_test
bind gpeb_top gpeb_props gpeb_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.gpio_in_b0, .gpio_in_b1, .rise_en_b0, .rise_en_b1, .fall_en_b0, .fall_en_b1,
	.edge_status_b0, .edge_status_b1, .irq);
